/* File: logic/cpu_reg_set.sv */
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE1 - An on-chip RAM of 128 eight-bit locations sits beside the registers.
// RULE2 - The lowest 32 RAM bytes keep their contents while ram_enable holds the RAM in standby.
// RULE3 - On the variant without standby the system holds the standby supply at 5 V.
// RULE4 - On the variant without RAM the system grounds ram_enable and all memory is external.
// RULE5 - A 16-bit program counter with high and low bytes holds the current instruction address.
// RULE6 - A two-byte stack pointer holds the next free location of the external stack.
// RULE7 - A 16-bit index register with high and low bytes holds data or an address.
// RULE8 - Two 8-bit accumulators feed the ALU and take its results; here only A takes the results.
// RULE9 - After each ALU operation the condition codes record N, Z, V, C from bit 7, H from bit 3; here only ADD sets H and AND leaves C as it was.
// RULE10 - Conditional branches decide on the flags held in the condition codes.
// RULE11 - Bit 4 of the condition codes is the interrupt mask.
// RULE12 - Condition code bits 6 and 7 always read as one.
// RULE13 - On fast grades software does not fetch instructions from on-chip RAM.
// RULE14 - Addresses 0000 to 007F hit the internal RAM and the data bus then drives outward.
// RULE15 - Entering an interrupt saves index, program counter, accumulators and condition codes.
// RULE16 - Push order is PC low, PC high, IX low, IX high, A, B, CC, decrementing SP after each.
// RULE17 - Restore increments SP before each pull and restores in reverse push order.
module cpu_reg_set #(
    parameter int BUS_DIV = cpu_regs_pkg::BUS_DIV_CYCLES
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  ram_enable,
    input  wire logic [7:0]            bus_data_in,
    output cpu_regs_pkg::sys_bus_t     sys_bus
);
    import cpu_regs_pkg::*;

    localparam int DIV_W      = $clog2(BUS_DIV + 1);
    localparam int PUSH_BOUND = 1000;

    logic [15:0]      pc_q, pc_d, sp_q, sp_d, ix_q, ix_d;
    logic [7:0]       a_q, a_d, b_q, b_d, cc_q, cc_d;
    seq_state_t       st_q, st_d;
    logic [2:0]       idx_q, idx_d;
    logic [DIV_W-1:0] div_q;
    logic             taken_q, taken_d, lost_q, lost_d, rd_wait_q, rd_wait_d;
    sys_bus_t         bus_q, bus_d;
    logic             re_s1_q, re_s2_q;
    logic [7:0]       din_s1_q, din_s2_q;
    logic             tick, busy;
    logic             apb_acc, apb_wr, apb_rd, ram_sel, reg_sel, apb_err, ram_rd_first;
    logic [RAM_AW-1:0] apb_idx, ram_addr;
    logic             ram_en, ram_we;
    logic [7:0]       ram_wdata, ram_rdata, pull_byte, push_byte;
    logic [8:0]       alu_r;
    logic [2:0]       k;
    logic [15:0]      sp_inc;

    // Two flops on pins from outside the clock domain
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            re_s1_q  <= 1'b0;
            re_s2_q  <= 1'b0;
            din_s1_q <= 8'h00;
            din_s2_q <= 8'h00;
        end
        else
        begin
            re_s1_q  <= ram_enable;
            re_s2_q  <= re_s1_q;
            din_s1_q <= bus_data_in;
            din_s2_q <= din_s1_q;
        end
    end

    // Bus cycle enable; a push steps one byte per tick, a pull one byte per two ticks
    assign tick = (div_q == DIV_W'(BUS_DIV - 1));
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_q <= '0;
        end
        else
        begin
            div_q <= tick ? '0 : div_q + DIV_W'(1);
        end
    end

    assign busy    = (st_q != S_IDLE);
    assign apb_acc = psel && penable;
    assign apb_wr  = apb_acc && pwrite;
    assign apb_rd  = apb_acc && !pwrite;
    assign apb_idx = paddr[RAM_AW+1:2];
    assign ram_sel = (paddr >= OFS_RAM_BASE) && (paddr <= OFS_RAM_END) && (paddr[1:0] == 2'b00);
    assign reg_sel = (paddr == OFS_PC) || (paddr == OFS_SP) || (paddr == OFS_IX)
                  || (paddr == OFS_ACC_A) || (paddr == OFS_ACC_B) || (paddr == OFS_CC)
                  || (paddr == OFS_CMD) || (paddr == OFS_STATUS);
    // Sequencer owns the RAM port and the registers while busy
    assign apb_err = (!ram_sel && !reg_sel)
                  || (ram_sel && (busy || !re_s2_q))
                  || (pwrite && busy && paddr != OFS_STATUS);
    assign ram_rd_first = apb_rd && ram_sel && !apb_err && !rd_wait_q;
    assign rd_wait_d    = ram_rd_first;
    assign pready       = !ram_rd_first;
    assign pslverr      = apb_acc && pready && apb_err;
    assign sp_inc       = sp_q + 16'h0001;
    assign k            = 3'(STACK_BYTES - 1) - idx_q;

    byte_ram #(
        .DEPTH (RAM_DEPTH),
        .AW    (RAM_AW),
        .WIDTH (8)
    ) u_ram ( // RULE1
        .clk   (pclk),
        .rst_n (presetn),
        .en    (ram_en),
        .we    (ram_we),
        .addr  (ram_addr),
        .wdata (ram_wdata),
        .rdata (ram_rdata)
    );

    always_comb
    begin
        case (idx_q)
            3'd0:    push_byte = pc_q[7:0];
            3'd1:    push_byte = pc_q[15:8];
            3'd2:    push_byte = ix_q[7:0];
            3'd3:    push_byte = ix_q[15:8];
            3'd4:    push_byte = a_q;
            3'd5:    push_byte = b_q;
            default: push_byte = cc_q;
        endcase // RULE16
    end

    // Upper bytes lost in standby read as zero until software clears the flag
    always_comb
    begin
        pull_byte = din_s2_q;
        if (is_internal(sp_q, re_s2_q))
        begin
            pull_byte = (lost_q && sp_q[RAM_AW-1:0] >= RAM_AW'(RAM_KEEP)) ? 8'h00 : ram_rdata;
        end
    end

    always_comb
    begin
        pc_d = pc_q;
        sp_d = sp_q;
        ix_d = ix_q;
        a_d = a_q;
        b_d = b_q;
        cc_d = cc_q;
        st_d = st_q;
        idx_d = idx_q;
        taken_d = taken_q;
        lost_d = lost_q;
        bus_d = bus_q;
        ram_en = ram_rd_first;
        ram_we = 1'b0;
        ram_addr = apb_idx;
        ram_wdata = pwdata[7:0];
        alu_r = 9'h000;
        if (apb_wr && !apb_err)
        begin
            if (paddr == OFS_PC)
                pc_d = pwdata[15:0]; // RULE5
            else if (paddr == OFS_SP)
                sp_d = pwdata[15:0]; // RULE6
            else if (paddr == OFS_IX)
                ix_d = pwdata[15:0]; // RULE7
            else if (paddr == OFS_ACC_A)
                a_d = pwdata[7:0]; // RULE8
            else if (paddr == OFS_ACC_B)
                b_d = pwdata[7:0]; // RULE8
            else if (paddr == OFS_CC)
                cc_d = pwdata[7:0] | CC_ONES; // RULE12
            else if (paddr == OFS_STATUS)
            begin
                if (pwdata[ST_LOST])
                    lost_d = 1'b0;
            end
            else if (paddr == OFS_CMD)
            begin
                case (pwdata[3:0])
                    OP_ADD, OP_SUB, OP_AND:
                    begin
                        if (pwdata[3:0] == OP_ADD)
                            alu_r = {1'b0, a_q} + {1'b0, b_q};
                        else if (pwdata[3:0] == OP_SUB)
                            alu_r = {1'b0, a_q} - {1'b0, b_q};
                        else
                            alu_r = {1'b0, a_q & b_q};
                        a_d = alu_r[7:0]; // RULE8
                        cc_d[CC_N] = alu_r[7]; // RULE9
                        cc_d[CC_Z] = (alu_r[7:0] == 8'h00); // RULE9
                        if (pwdata[3:0] == OP_ADD)
                        begin
                            cc_d[CC_C] = alu_r[8]; // RULE9
                            cc_d[CC_H] = (a_q[3] & b_q[3]) | (b_q[3] & !alu_r[3])
                                       | (!alu_r[3] & a_q[3]); // RULE9
                            cc_d[CC_V] = (a_q[7] & b_q[7] & !alu_r[7])
                                       | (!a_q[7] & !b_q[7] & alu_r[7]); // RULE9
                        end
                        else if (pwdata[3:0] == OP_SUB)
                        begin
                            cc_d[CC_C] = alu_r[8]; // RULE9
                            cc_d[CC_V] = (a_q[7] & !b_q[7] & !alu_r[7])
                                       | (!a_q[7] & b_q[7] & alu_r[7]); // RULE9
                        end
                        else
                            cc_d[CC_V] = 1'b0; // RULE9
                    end
                    OP_BRANCH:
                    begin
                        taken_d = branch_taken(cc_q, pwdata[6:4]); // RULE10
                        if (taken_d)
                            pc_d = pc_q + {{8{pwdata[15]}}, pwdata[15:8]}; // RULE10
                    end
                    OP_INT:
                    begin
                        st_d = S_PUSH; // RULE15
                        idx_d = 3'd0;
                    end
                    OP_RTI:
                    begin
                        st_d = S_PULL_ADDR; // RULE17
                        idx_d = 3'd0;
                    end
                    default: st_d = st_q;
                endcase
            end
            else
            begin
                ram_en = 1'b1;
                ram_we = 1'b1;
            end
        end
        case (st_q)
            S_PUSH:
            begin
                if (tick)
                begin
                    bus_d = '{addr: sp_q, data: push_byte, rw: 1'b0, valid: 1'b1,
                              data_oe: 1'b1};
                    if (is_internal(sp_q, re_s2_q))
                    begin
                        ram_en = 1'b1; // RULE14
                        ram_we = 1'b1;
                        ram_addr = sp_q[RAM_AW-1:0];
                        ram_wdata = push_byte;
                    end
                    sp_d = sp_q - 16'h0001; // RULE16
                    idx_d = idx_q + 3'd1;
                    if (idx_q == 3'(STACK_BYTES - 1))
                    begin
                        st_d = S_IDLE;
                        cc_d[CC_I] = 1'b1; // RULE11
                    end
                end
            end
            S_PULL_ADDR:
            begin
                if (tick)
                begin
                    sp_d = sp_inc; // RULE17
                    bus_d.addr = sp_inc;
                    bus_d.rw = 1'b1;
                    bus_d.valid = 1'b1;
                    // Internal hit drives outward so external data is ignored
                    bus_d.data_oe = is_internal(sp_inc, re_s2_q); // RULE14
                    if (is_internal(sp_inc, re_s2_q))
                    begin
                        ram_en = 1'b1;
                        ram_addr = sp_inc[RAM_AW-1:0];
                    end
                    st_d = S_PULL_DATA;
                end
            end
            S_PULL_DATA:
            begin
                if (tick)
                begin
                    bus_d.data = bus_q.data_oe ? pull_byte : bus_q.data;
                    case (k)
                        3'd0:    pc_d[7:0] = pull_byte; // RULE17
                        3'd1:    pc_d[15:8] = pull_byte;
                        3'd2:    ix_d[7:0] = pull_byte;
                        3'd3:    ix_d[15:8] = pull_byte;
                        3'd4:    a_d = pull_byte;
                        3'd5:    b_d = pull_byte;
                        default: cc_d = pull_byte | CC_ONES; // RULE12
                    endcase
                    idx_d = idx_q + 3'd1;
                    st_d = (idx_q == 3'(STACK_BYTES - 1)) ? S_IDLE : S_PULL_ADDR;
                end
            end
            default:
            begin
                bus_d.valid = 1'b0;
                bus_d.rw = 1'b1;
                bus_d.data_oe = 1'b0;
            end
        endcase
        // Standby marks the upper bytes lost; set wins over a clear
        if (!re_s2_q)
            lost_d = 1'b1; // RULE2
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pc_q <= PC_RESET;
            sp_q <= SP_RESET;
            ix_q <= IX_RESET;
            a_q <= ACC_RESET;
            b_q <= ACC_RESET;
            cc_q <= CC_RESET;
            st_q <= S_IDLE;
            idx_q <= 3'd0;
            taken_q <= 1'b0;
            lost_q <= 1'b1;
            rd_wait_q <= 1'b0;
            bus_q <= '{addr: 16'h0000, data: 8'h00, rw: 1'b1, valid: 1'b0, data_oe: 1'b0};
        end
        else
        begin
            pc_q <= pc_d;
            sp_q <= sp_d;
            ix_q <= ix_d;
            a_q <= a_d;
            b_q <= b_d;
            cc_q <= cc_d;
            st_q <= st_d;
            idx_q <= idx_d;
            taken_q <= taken_d;
            lost_q <= lost_d;
            rd_wait_q <= rd_wait_d;
            bus_q <= bus_d;
        end
    end

    assign sys_bus = bus_q;

    always_comb
    begin
        prdata = 32'h0000_0000;
        if (apb_rd && !apb_err)
        begin
            if (paddr == OFS_PC)
                prdata[15:0] = pc_q;
            else if (paddr == OFS_SP)
                prdata[15:0] = sp_q;
            else if (paddr == OFS_IX)
                prdata[15:0] = ix_q;
            else if (paddr == OFS_ACC_A)
                prdata[7:0] = a_q;
            else if (paddr == OFS_ACC_B)
                prdata[7:0] = b_q;
            else if (paddr == OFS_CC)
                prdata[7:0] = cc_q | CC_ONES; // RULE12
            else if (paddr == OFS_STATUS)
                prdata[3:0] = {re_s2_q, lost_q, taken_q, busy};
            else if (ram_sel)
                prdata[7:0] = (lost_q && apb_idx >= RAM_AW'(RAM_KEEP)) ? 8'h00 : ram_rdata; // RULE2
        end
    end

    sequence s_push_done;
        (st_q == S_PUSH) ##[1:PUSH_BOUND] (st_q == S_IDLE);
    endsequence

    property p_cc_ones;
        @(posedge pclk) disable iff (!presetn) cc_q[7:6] == 2'b11;
    endproperty
    a_cc_ones: assert property (p_cc_ones) else $error("cc upper bits not one"); // RULE12

    property p_push_dec;
        @(posedge pclk) disable iff (!presetn)
        (st_q == S_PUSH && tick) |=> (sp_q == $past(sp_q) - 16'h0001) && !sys_bus.rw;
    endproperty
    a_push_dec: assert property (p_push_dec) else $error("push did not decrement sp"); // RULE16

    property p_pull_inc;
        @(posedge pclk) disable iff (!presetn)
        (st_q == S_PULL_ADDR && tick) |=> (sp_q == $past(sp_q) + 16'h0001)
            && sys_bus.addr == sp_q && sys_bus.rw;
    endproperty
    a_pull_inc: assert property (p_pull_inc) else $error("pull did not pre-increment sp"); // RULE17

    property p_int_done;
        @(posedge pclk) disable iff (!presetn)
        (apb_wr && !apb_err && paddr == OFS_CMD && pwdata[3:0] == OP_INT) |=> s_push_done;
    endproperty
    a_int_done: assert property (p_int_done) else $error("interrupt save did not finish"); // RULE15

    property p_mask_set;
        @(posedge pclk) disable iff (!presetn)
        (st_q == S_PUSH && tick && idx_q == 3'(STACK_BYTES - 1))
            |=> cc_q[CC_I] && st_q == S_IDLE && sys_bus.data == $past(cc_q);
    endproperty
    a_mask_set: assert property (p_mask_set) else $error("mask not set after save"); // RULE11

    property p_int_drive;
        @(posedge pclk) disable iff (!presetn)
        (st_q == S_PULL_ADDR && tick && is_internal(sp_inc, re_s2_q)) |=> sys_bus.data_oe;
    endproperty
    a_int_drive: assert property (p_int_drive) else $error("internal read not driven out"); // RULE14

    property p_alu_zero;
        @(posedge pclk) disable iff (!presetn)
        (apb_wr && !apb_err && paddr == OFS_CMD && pwdata[3:0] == OP_ADD)
            |=> cc_q[CC_Z] == (a_q == 8'h00) && cc_q[CC_N] == a_q[7];
    endproperty
    a_alu_zero: assert property (p_alu_zero) else $error("alu flags wrong"); // RULE9

    property p_branch;
        @(posedge pclk) disable iff (!presetn)
        (apb_wr && !apb_err && paddr == OFS_CMD && pwdata[3:0] == OP_BRANCH
            && pwdata[6:4] == BR_EQ) |=> taken_q == $past(cc_q[CC_Z]);
    endproperty
    a_branch: assert property (p_branch) else $error("branch ignored zero flag"); // RULE10
endmodule // cpu_reg_set
`default_nettype wire

/* File: pkg/cpu_regs_pkg.sv */
`default_nettype none
package cpu_regs_pkg;
    localparam int RAM_DEPTH   = 128;
    localparam int RAM_KEEP    = 32;
    localparam int RAM_AW      = 7;
    localparam int STACK_BYTES = 7;

    localparam logic [11:0] OFS_PC       = 12'h000;
    localparam logic [11:0] OFS_SP       = 12'h004;
    localparam logic [11:0] OFS_IX       = 12'h008;
    localparam logic [11:0] OFS_ACC_A    = 12'h00C;
    localparam logic [11:0] OFS_ACC_B    = 12'h010;
    localparam logic [11:0] OFS_CC       = 12'h014;
    localparam logic [11:0] OFS_CMD      = 12'h018;
    localparam logic [11:0] OFS_STATUS   = 12'h01C;
    localparam logic [11:0] OFS_RAM_BASE = 12'h200;
    localparam logic [11:0] OFS_RAM_END  = 12'h3FC;

    localparam int CC_C = 0;
    localparam int CC_V = 1;
    localparam int CC_Z = 2;
    localparam int CC_N = 3;
    localparam int CC_I = 4;
    localparam int CC_H = 5;
    localparam logic [7:0]  CC_ONES  = 8'hC0;
    localparam logic [7:0]  CC_RESET = 8'hD0;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] SP_RESET = 16'h0000;
    localparam logic [15:0] IX_RESET = 16'h0000;
    localparam logic [7:0]  ACC_RESET = 8'h00;
    localparam logic [15:0] RAM_LIMIT = 16'h0080;

    localparam int ST_BUSY  = 0;
    localparam int ST_TAKEN = 1;
    localparam int ST_LOST  = 2;
    localparam int ST_RAMEN = 3;

    localparam logic [3:0] OP_ADD    = 4'h1;
    localparam logic [3:0] OP_SUB    = 4'h2;
    localparam logic [3:0] OP_AND    = 4'h3;
    localparam logic [3:0] OP_BRANCH = 4'h4;
    localparam logic [3:0] OP_INT    = 4'h5;
    localparam logic [3:0] OP_RTI    = 4'h6;

    localparam logic [2:0] BR_ALWAYS = 3'h0;
    localparam logic [2:0] BR_EQ     = 3'h1;
    localparam logic [2:0] BR_NE     = 3'h2;
    localparam logic [2:0] BR_MI     = 3'h3;
    localparam logic [2:0] BR_PL     = 3'h4;
    localparam logic [2:0] BR_CS     = 3'h5;
    localparam logic [2:0] BR_CC     = 3'h6;
    localparam logic [2:0] BR_VS     = 3'h7;

    localparam int CLK_NS         = 8;
    localparam int BUS_CYCLE_NS   = 1000;
    localparam int BUS_DIV_CYCLES = (BUS_CYCLE_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {
        S_IDLE      = 2'b00,
        S_PUSH      = 2'b01,
        S_PULL_ADDR = 2'b11,
        S_PULL_DATA = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
        logic        rw;
        logic        valid;
        logic        data_oe;
    } sys_bus_t;

    function automatic logic is_internal(input logic [15:0] addr, input logic re);
        return re && (addr < RAM_LIMIT);
    endfunction

    function automatic logic branch_taken(input logic [7:0] cc, input logic [2:0] cond);
        logic t;
        t = 1'b0;
        case (cond)
            BR_ALWAYS: t = 1'b1;
            BR_EQ:     t = cc[CC_Z];
            BR_NE:     t = !cc[CC_Z];
            BR_MI:     t = cc[CC_N];
            BR_PL:     t = !cc[CC_N];
            BR_CS:     t = cc[CC_C];
            BR_CC:     t = !cc[CC_C];
            default:   t = cc[CC_V];
        endcase
        return t;
    endfunction
endpackage
`default_nettype wire

/* File: logic/byte_ram.sv */
`timescale 1ns/1ps
`default_nettype none
module byte_ram #(
    parameter int DEPTH = 128,
    parameter int AW    = 7,
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             en,
    input  wire logic             we,
    input  wire logic [AW-1:0]    addr,
    input  wire logic [WIDTH-1:0] wdata,
    output logic      [WIDTH-1:0] rdata
);
    // No reset on the array: contents survive the processor reset
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk)
    begin
        if (en && we)
        begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata <= '0;
        end
        else if (en && !we)
        begin
            rdata <= mem[addr];
        end
    end
endmodule // byte_ram
`default_nettype wire

/* File: dv/ext_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_mem (
    input  wire logic                   pclk,
    input  wire cpu_regs_pkg::sys_bus_t sys_bus,
    output logic [7:0]                  bus_data_in
);
    import cpu_regs_pkg::*;
    // Whole 64K space backed here for reads; stores below 0080 are dropped
    logic [7:0] mem [0:65535];
    logic [7:0] last_q = 8'h00;
    logic       rd;
    // Standby supply held at 5 V, not modelled as a signal
    // Only stack data passes here, never instruction fetches
    assign rd = sys_bus.valid && sys_bus.rw && !sys_bus.data_oe;
    // Low addresses left to the internal RAM, as external RAM is disabled there
    always @(posedge pclk)
        if (sys_bus.valid && !sys_bus.rw && sys_bus.addr >= 16'h0080)
            mem[sys_bus.addr] <= sys_bus.data;
    always @(posedge pclk)
        if (rd)
            last_q <= mem[sys_bus.addr];
    // Released bus shows the inverse, so a stale byte never passes
    assign bus_data_in = rd ? mem[sys_bus.addr] : ~last_q;
endmodule // ext_mem
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cpu_regs_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, e, ram_enable = 1'b1;
    logic [7:0]  bus_data_in, a, b, c;
    logic [15:0] pc, ix;
    sys_bus_t    sys_bus;
    int seed = 85, err_count = 0, check_count = 0, cycles = 0;
    always #4 pclk = ~pclk;
    cpu_reg_set #(.BUS_DIV(4)) cpu_reg_set_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ram_enable(ram_enable),
        .bus_data_in(bus_data_in), .sys_bus(sys_bus));
    ext_mem ext_mem_i (.pclk(pclk), .sys_bus(sys_bus), .bus_data_in(bus_data_in));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            err_count++;
            complete_run();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Request held until pready seen at an edge, then released
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd_chk(input string what, input logic [11:0] ad, input logic [31:0] exp);
        apb(1'b0, ad, 32'h0);
        chk(what, r, exp);
    endtask
    task automatic wait_idle();
        do
        begin
            apb(1'b0, OFS_STATUS, 32'h0);
        end while (r[ST_BUSY] !== 1'b0);
    endtask
    // Expected {cc, result} of one ALU command, CC starting at C0
    function automatic logic [15:0] alu(input logic [3:0] op, input logic [7:0] x, y);
        logic [8:0] s;
        logic v, h;
        s = (op == OP_ADD) ? x + y : (op == OP_SUB) ? x - y : {1'b0, x & y};
        v = (op == OP_ADD) ? (x[7] == y[7] && s[7] != x[7]) :
            (op == OP_SUB) ? (x[7] != y[7] && s[7] != x[7]) : 1'b0;
        h = (op == OP_ADD) && ({1'b0, x[3:0]} + {1'b0, y[3:0]} > 5'h0F);
        return {2'b11, h, 1'b0, s[7], s[7:0] == 8'h00, v, s[8], s[7:0]};
    endfunction
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk("pc", OFS_PC, 32'h0);
        rd_chk("sp", OFS_SP, 32'h0);
        rd_chk("ix", OFS_IX, 32'h0);
        rd_chk("cc", OFS_CC, 32'hD0);
        apb(1'b1, OFS_CC, 32'h0);
        rd_chk("cc", OFS_CC, 32'hC0);
        for (int i = 0; i < 24; i++)
        begin
            a = $random(seed);
            b = (i == 0) ? 8'h01 : $random(seed);
            if (i == 0) a = 8'hFF;
            c = OP_ADD + i % 3;
            apb(1'b1, OFS_ACC_A, {24'h0, a});
            apb(1'b1, OFS_ACC_B, {24'h0, b});
            apb(1'b1, OFS_CC, 32'hC0);
            apb(1'b1, OFS_CMD, {28'h0, c[3:0]});
            rd_chk("acc_a", OFS_ACC_A, {24'h0, 8'(alu(c[3:0], a, b))});
            rd_chk("acc_b", OFS_ACC_B, {24'h0, b});
            rd_chk("cc_alu", OFS_CC, {24'h0, 8'(alu(c[3:0], a, b) >> 8)});
        end
        for (int k = 0; k < 16; k++)
        begin
            c = $random(seed);
            b = $random(seed);
            apb(1'b1, OFS_PC, 32'h1000);
            apb(1'b1, OFS_CC, {24'h0, c});
            apb(1'b1, OFS_CMD, {16'h0, b, 1'b0, k[2:0], OP_BRANCH});
            a = {5'h0, k[2:0]};
            e = (a == 0) | (a == 1 & c[2]) | (a == 2 & !c[2]) | (a == 3 & c[3]) |
                (a == 4 & !c[3]) | (a == 5 & c[0]) | (a == 6 & !c[0]) | (a == 7 & c[1]);
            rd_chk("pc_br", OFS_PC, e ? 32'h1000 + {{24{b[7]}}, b} : 32'h1000);
        end
        pc = $random(seed);
        ix = $random(seed);
        a = $random(seed);
        b = $random(seed);
        apb(1'b1, OFS_PC, {16'h0, pc});
        apb(1'b1, OFS_IX, {16'h0, ix});
        apb(1'b1, OFS_ACC_A, {24'h0, a});
        apb(1'b1, OFS_ACC_B, {24'h0, b});
        apb(1'b1, OFS_CC, 32'h05);
        apb(1'b1, OFS_SP, 32'h01FF);
        apb(1'b1, OFS_CMD, {28'h0, OP_INT});
        wait_idle();
        chk("stack", {ext_mem_i.mem[16'h01FF], ext_mem_i.mem[16'h01FE], ext_mem_i.mem[16'h01FD],
            ext_mem_i.mem[16'h01FC]}, {pc[7:0], pc[15:8], ix[7:0], ix[15:8]});
        chk("stack", {ext_mem_i.mem[16'h01FB], ext_mem_i.mem[16'h01FA], ext_mem_i.mem[16'h01F9]},
            {a, b, 8'hC5});
        rd_chk("sp_int", OFS_SP, 32'h01F8);
        rd_chk("cc_int", OFS_CC, 32'hD5);
        for (int i = 0; i < 5; i++)
            apb(1'b1, OFS_PC + 4 * i, 32'h0);
        apb(1'b1, OFS_SP, 32'h01F8);
        apb(1'b1, OFS_CMD, {28'h0, OP_RTI});
        wait_idle();
        rd_chk("pc_rti", OFS_PC, {16'h0, pc});
        rd_chk("ix_rti", OFS_IX, {16'h0, ix});
        rd_chk("a_rti", OFS_ACC_A, {24'h0, a});
        rd_chk("b_rti", OFS_ACC_B, {24'h0, b});
        rd_chk("sp_rti", OFS_SP, 32'h01FF);
        // Stack inside the on-chip RAM: save then restore
        apb(1'b1, OFS_SP, 32'h0010);
        apb(1'b1, OFS_CMD, {28'h0, OP_INT});
        wait_idle();
        apb(1'b1, OFS_CMD, {28'h0, OP_RTI});
        wait_idle();
        rd_chk("pc_ram_rti", OFS_PC, {16'h0, pc});
        // Lost flag is set out of reset; clear it before using upper bytes
        apb(1'b1, OFS_STATUS, 32'h4);
        rd_chk("ram_stack", OFS_RAM_BASE + 12'h040, {24'h0, pc[7:0]});
        apb(1'b1, OFS_RAM_BASE + 12'h014, 32'hA5);
        apb(1'b1, OFS_RAM_BASE + 12'h0A0, 32'h5A);
        apb(1'b1, OFS_RAM_END, 32'h3C);
        rd_chk("ram_top", OFS_RAM_END, 32'h3C);
        rd_chk("ram_hi", OFS_RAM_BASE + 12'h0A0, 32'h5A);
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped_err", {31'h0, e}, 32'h1);
        ram_enable <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b0, OFS_RAM_BASE, 32'h0);
        chk("standby_err", {31'h0, e}, 32'h1);
        ram_enable <= 1'b1;
        repeat (4) @(posedge pclk);
        rd_chk("ram_kept", OFS_RAM_BASE + 12'h014, 32'hA5);
        rd_chk("ram_lost", OFS_RAM_BASE + 12'h0A0, 32'h0);
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
